// *** rtl/fpp_pkg.sv ***
// Constants, register layout and state types for the array program sequencer
package fpp_pkg;

    // ****************************************
    // Device address map (register index = address, byte address = 4 x index)
    // ****************************************
    localparam logic [15:0] CTRL_ADDR   = 16'hFE08;
    localparam logic [15:0] STAT_ADDR   = 16'hFE0C;
    localparam logic [15:0] PROT_ADDR   = 16'hFFF0;
    localparam logic [15:0] ARRAY_BASE  = 16'h7800;
    localparam logic [15:0] ARRAY_END   = 16'h7FEF;
    localparam logic [11:0] VEC_PAGE    = 12'hFFF;
    localparam logic [4:0]  ARRAY_PAGE  = 5'h0F;

    // ****************************************
    // Storage
    // ****************************************
    localparam int          ARRAY_BYTES = 2048;
    localparam int          VEC_BYTES   = 16;
    localparam int          MEM_DEPTH   = ARRAY_BYTES + VEC_BYTES;
    localparam logic [7:0]  ERASED_BYTE = 8'h00;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int          CTRL_DIV    = 0;
    localparam int          CTRL_BLK0   = 1;
    localparam int          CTRL_BLK1   = 2;
    localparam int          CTRL_HIGH_VOLTAGE_ENABLE   = 3;
    localparam int          CTRL_MARGIN = 4;
    localparam int          CTRL_ERASE  = 5;
    localparam int          CTRL_PGM    = 6;
    localparam logic [6:0]  CTRL_RST    = 7'h00;
    localparam logic [7:0]  PROT_RST    = 8'h00;

    // ****************************************
    // Timing and protection ranges
    // ****************************************
    localparam logic [3:0]  MARGIN_EXTRA = 4'h8;
    localparam logic [15:0] PROT_START [0:3] = '{16'h7800, 16'h7880, 16'h7900, 16'h7A00};
    localparam logic [10:0] BLK_MASK   [0:3] = '{11'h7FF, 11'h3FF, 11'h03F, 11'h007};

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_STRETCH,
        BUS_RESP
    } fpp_bus_e;

endpackage

// *** rtl/fpp_protect_check.sv ***
// Target range check against the latched protection byte
`timescale 1ns/1ps

module fpp_protect_check (
    input  wire logic [7:0]  prot,
    input  wire logic [15:0] addr,
    input  wire logic [10:0] mask,
    input  wire logic        bypass,
    output logic             hit
);

    logic [3:0]  bit_hit;
    logic [15:0] end_addr;
    logic        in_vec;
    logic        in_array;

    assign end_addr = addr | {5'h00, mask};
    assign in_vec   = addr[15:4] == fpp_pkg::VEC_PAGE;
    assign in_array = addr[15:11] == fpp_pkg::ARRAY_PAGE && addr <= fpp_pkg::ARRAY_END;

    // Union of all set ranges: each covers from its start up to the array end
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_range
            assign bit_hit[i] = prot[i] & (in_vec |
                (in_array & (end_addr >= fpp_pkg::PROT_START[i])));
        end
    endgenerate

    // Protection byte only alterable with the test voltage present
    assign hit = !bypass & ((|bit_hit) | (addr == fpp_pkg::PROT_ADDR));

endmodule

// *** rtl/fpp_pump_div.sv ***
// Charge pump clock divider, ticks only while high voltage is on
`timescale 1ns/1ps

module fpp_pump_div (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic divide,
    output logic      tick_q
);

    logic phase_q;
    logic phase_d;
    logic tick_d;

    always_comb
    begin
        phase_d = enable ? !phase_q : 1'b0;
        tick_d  = enable & (!divide | phase_q);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            phase_q <= 1'b0;
            tick_q  <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            tick_q  <= tick_d;
        end
    end

    property p_undivided;
        @(posedge clock) disable iff (rst)
        (enable && !divide) |=> tick_q;
    endproperty
    a_undivided: assert property (p_undivided) else $error("pump tick missing undivided");

    property p_halved;
        @(posedge clock) disable iff (rst)
        (enable && divide && tick_q) |=> !tick_q;
    endproperty
    a_halved: assert property (p_halved) else $error("pump tick not halved");

endmodule

// *** rtl/fpp_sequencer.sv ***
// Array program/margin-read sequencer with block protection, APB register access
`timescale 1ns/1ps

// Overview of operation
// - Erased byte reads as zero
// - Programming is one byte per operation
// - Program select latches next array write
// - Margin reads take eight extra cycles
// - Unrelated bus traffic never aborts sequence
// - Protection byte read is latched
// - Protected target clears program and erase
// - All-zero protection byte still guards the protection byte itself
// - Test voltage bypasses all protection
// - Upper bit guards 7A00 up and vectors
// - Mid bit guards 7900 up and vectors
// - Low bit guards 7880 up and vectors
// - Full bit guards whole array, vectors
// - Several bits protect union of ranges
// - Divider bit halves pump clock
// - High voltage needs selected op and sequence
// - Margin refused while high voltage on
// - Program and erase never both set
module fpp_sequencer (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        test_override_voltage,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             high_voltage_enable,
    output logic             pump_tick
);

    // ****************************************
    // State
    // ****************************************
    fpp_pkg::fpp_bus_e bus_q;
    fpp_pkg::fpp_bus_e bus_d;
    logic [3:0]        cnt_q;
    logic [3:0]        cnt_d;
    logic              pready_q;
    logic              pready_d;
    logic              pslverr_q;
    logic              pslverr_d;
    logic [31:0]       prdata_q;
    logic [31:0]       prdata_d;

    logic              div_q;
    logic              div_d;
    logic [1:0]        blk_q;
    logic [1:0]        blk_d;
    logic              high_voltage_enable_q;
    logic              high_voltage_enable_d;
    logic              margin_q;
    logic              margin_d;
    logic              erase_q;
    logic              erase_d;
    logic              pgm_q;
    logic              pgm_d;
    logic              prot_seen_q;
    logic              prot_seen_d;
    logic              latched_q;
    logic              latched_d;
    logic [7:0]        prot_q;
    logic [7:0]        prot_d;
    logic [15:0]       tgt_addr_q;
    logic [15:0]       tgt_addr_d;
    logic [7:0]        tgt_data_q;
    logic [7:0]        tgt_data_d;

    logic [7:0]        mem [0:fpp_pkg::MEM_DEPTH-1];

    // ****************************************
    // Address decode
    // ****************************************
    logic [15:0] addr;
    logic        aligned;
    logic        is_ctrl;
    logic        is_stat;
    logic        is_vec;
    logic        is_arr;
    logic        mapped;
    logic [11:0] idx;
    logic [11:0] tgt_idx;
    logic [7:0]  rd_byte;
    logic        acc;
    logic        done;
    logic        wr;
    logic        rd;
    logic        op_on;
    logic        hit;
    logic        hit_live;
    logic        hv_fall;
    logic [10:0] mask;
    logic        pgm_req;
    logic        erase_req;
    logic        hv_ok;

    function automatic logic [11:0] mem_index(input logic [15:0] a);
        if (a[15:4] == fpp_pkg::VEC_PAGE)
            mem_index = {8'h80, a[3:0]};
        else
            mem_index = {1'b0, a[10:0]};
    endfunction

    assign addr    = paddr[17:2];
    assign aligned = paddr[1:0] == 2'h0;
    assign is_vec  = aligned && addr[15:4] == fpp_pkg::VEC_PAGE;
    assign is_arr  = aligned && addr[15:11] == fpp_pkg::ARRAY_PAGE;
    assign is_ctrl = aligned && addr == fpp_pkg::CTRL_ADDR;
    assign is_stat = aligned && addr == fpp_pkg::STAT_ADDR;
    assign mapped  = is_vec | is_arr | is_ctrl | is_stat;
    assign idx     = mem_index(addr);
    assign tgt_idx = mem_index(tgt_addr_q);
    assign rd_byte = mem[idx];
    assign acc     = psel & penable;
    assign done    = acc & pready_q;
    assign wr      = done & pwrite & mapped;
    assign rd      = done & !pwrite & mapped;
    assign op_on   = pgm_q | erase_q;
    assign mask    = pgm_q ? 11'h000 : fpp_pkg::BLK_MASK[blk_q];
    assign hv_fall = high_voltage_enable_q & !high_voltage_enable_d;

    fpp_protect_check u_protect (
        .prot   (prot_q),
        .addr   (tgt_addr_q),
        .mask   (mask),
        .bypass (test_override_voltage),
        .hit    (hit)
    );

    fpp_pump_div u_pump (
        .clock  (clock),
        .rst    (rst),
        .enable (high_voltage_enable_q),
        .divide (div_q),
        .tick_q (pump_tick)
    );

    assign hit_live = op_on & prot_seen_q & latched_q & !high_voltage_enable_q & hit;
    assign hv_ok    = op_on & prot_seen_q & latched_q & !hit;

    // ****************************************
    // APB slave handshake
    // ****************************************
    always_comb
    begin
        bus_d     = bus_q;
        cnt_d     = cnt_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        prdata_d  = 32'h0000_0000;
        case (bus_q)
            fpp_pkg::BUS_IDLE:
            begin
                if (acc)
                begin
                    if (!pwrite && (is_arr || is_vec) && margin_q)
                    begin
                        bus_d = fpp_pkg::BUS_STRETCH;
                        cnt_d = fpp_pkg::MARGIN_EXTRA;
                    end
                    else
                    begin
                        bus_d    = fpp_pkg::BUS_RESP;
                        pready_d = 1'b1;
                    end
                end
            end
            fpp_pkg::BUS_STRETCH:
            begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1)
                begin
                    bus_d    = fpp_pkg::BUS_RESP;
                    pready_d = 1'b1;
                end
            end
            default:
            begin
                bus_d = fpp_pkg::BUS_IDLE;
            end
        endcase
        if (pready_d)
        begin
            pslverr_d = !mapped;
            if (!pwrite)
            begin
                if (is_arr || is_vec)
                    prdata_d = {24'h000000, rd_byte};
                else if (is_ctrl)
                    prdata_d = {25'h0, pgm_q, erase_q, margin_q, high_voltage_enable_q, blk_q, div_q};
                else if (is_stat)
                    prdata_d = {22'h0, prot_q, latched_q, prot_seen_q};
                else
                    prdata_d = 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // Control sequence
    // ****************************************
    always_comb
    begin
        div_d       = div_q;
        blk_d       = blk_q;
        high_voltage_enable_d      = high_voltage_enable_q;
        margin_d    = margin_q;
        erase_d     = erase_q;
        pgm_d       = pgm_q;
        prot_seen_d = prot_seen_q;
        latched_d   = latched_q;
        prot_d      = prot_q;
        tgt_addr_d  = tgt_addr_q;
        tgt_data_d  = tgt_data_q;
        pgm_req     = pwdata[fpp_pkg::CTRL_PGM];
        erase_req   = pwdata[fpp_pkg::CTRL_ERASE];
        if (wr && is_ctrl)
        begin
            div_d    = pwdata[fpp_pkg::CTRL_DIV];
            blk_d    = {pwdata[fpp_pkg::CTRL_BLK1], pwdata[fpp_pkg::CTRL_BLK0]};
            pgm_d    = pgm_req & !erase_req & !(erase_q & erase_req);
            erase_d  = erase_req & !pgm_req;
            high_voltage_enable_d   = pwdata[fpp_pkg::CTRL_HIGH_VOLTAGE_ENABLE] & hv_ok & (pgm_d | erase_d);
            margin_d = pwdata[fpp_pkg::CTRL_MARGIN] & !high_voltage_enable_q & !high_voltage_enable_d;
            if ((pgm_d != pgm_q) || (erase_d != erase_q))
            begin
                prot_seen_d = 1'b0;
                latched_d   = 1'b0;
            end
        end
        // Other traffic leaves the sequence untouched
        if (rd && is_vec && addr == fpp_pkg::PROT_ADDR)
        begin
            prot_d = rd_byte;
            if (op_on)
                prot_seen_d = 1'b1;
        end
        if (wr && (is_arr || is_vec) && op_on && !latched_q && !high_voltage_enable_q)
        begin
            tgt_addr_d = addr;
            tgt_data_d = pwdata[7:0];
            latched_d  = 1'b1;
        end
        if (hit_live)
        begin
            pgm_d       = 1'b0;
            erase_d     = 1'b0;
            high_voltage_enable_d      = 1'b0;
            latched_d   = 1'b0;
            prot_seen_d = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bus_q       <= fpp_pkg::BUS_IDLE;
            cnt_q       <= 4'h0;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            prdata_q    <= 32'h0000_0000;
            {pgm_q, erase_q, margin_q, high_voltage_enable_q, blk_q, div_q} <= fpp_pkg::CTRL_RST;
            prot_seen_q <= 1'b0;
            latched_q   <= 1'b0;
            prot_q      <= fpp_pkg::PROT_RST;
            tgt_addr_q  <= 16'h0000;
            tgt_data_q  <= 8'h00;
        end
        else
        begin
            bus_q       <= bus_d;
            cnt_q       <= cnt_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            prdata_q    <= prdata_d;
            div_q       <= div_d;
            blk_q       <= blk_d;
            high_voltage_enable_q      <= high_voltage_enable_d;
            margin_q    <= margin_d;
            erase_q     <= erase_d;
            pgm_q       <= pgm_d;
            prot_seen_q <= prot_seen_d;
            latched_q   <= latched_d;
            prot_q      <= prot_d;
            tgt_addr_q  <= tgt_addr_d;
            tgt_data_q  <= tgt_data_d;
        end
    end

    // ****************************************
    // Array cells: high voltage pulse end commits
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (!rst && hv_fall && pgm_q)
            mem[tgt_idx] <= mem[tgt_idx] | tgt_data_q;
        if (!rst && hv_fall && erase_q)
        begin
            for (int i = 0; i < fpp_pkg::MEM_DEPTH; i++)
            begin
                if (i >= fpp_pkg::ARRAY_BYTES)
                begin
                    if (tgt_idx[11])
                        mem[i] <= fpp_pkg::ERASED_BYTE;
                end
                else if (!tgt_idx[11] && ((11'(i) | mask) == (tgt_idx[10:0] | mask)))
                    mem[i] <= fpp_pkg::ERASED_BYTE;
            end
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign high_voltage_enable = high_voltage_enable_q;

    // ****************************************
    // Checks
    // ****************************************
    property p_margin_stretch;
        @(posedge clock) disable iff (rst)
        ($rose(acc) && !pwrite && (is_arr || is_vec) && margin_q && bus_q == fpp_pkg::BUS_IDLE)
            |=> !pready_q [*8] ##1 pready_q;
    endproperty
    a_margin_stretch: assert property (p_margin_stretch) else $error("margin read not stretched");

    property p_plain_answer;
        @(posedge clock) disable iff (rst)
        ($rose(acc) && !(!pwrite && (is_arr || is_vec) && margin_q) && bus_q == fpp_pkg::BUS_IDLE)
            |=> pready_q;
    endproperty
    a_plain_answer: assert property (p_plain_answer) else $error("plain access not one wait");

    property p_interlock;
        @(posedge clock) disable iff (rst)
        !(pgm_q && erase_q);
    endproperty
    a_interlock: assert property (p_interlock) else $error("program and erase both set");

    property p_margin_block;
        @(posedge clock) disable iff (rst)
        $rose(margin_q) |-> !$past(high_voltage_enable_q) && !high_voltage_enable_q;
    endproperty
    a_margin_block: assert property (p_margin_block) else $error("margin set with high voltage");

    property p_hv_gate;
        @(posedge clock) disable iff (rst)
        $rose(high_voltage_enable_q) |-> $past(op_on && prot_seen_q && latched_q && !hit);
    endproperty
    a_hv_gate: assert property (p_hv_gate) else $error("high voltage out of sequence");

    property p_violation;
        @(posedge clock) disable iff (rst)
        hit_live |=> !pgm_q && !erase_q && !high_voltage_enable_q && !latched_q;
    endproperty
    a_violation: assert property (p_violation) else $error("protected target not cancelled");

    property p_prot_capture;
        @(posedge clock) disable iff (rst)
        (rd && is_vec && addr == fpp_pkg::PROT_ADDR) |=> prot_q === $past(rd_byte);
    endproperty
    a_prot_capture: assert property (p_prot_capture) else $error("protection byte not latched");

    property p_latch;
        @(posedge clock) disable iff (rst)
        (wr && is_arr && op_on && !latched_q && !high_voltage_enable_q && !hit_live)
            |=> latched_q && tgt_data_q == $past(pwdata[7:0]) && tgt_addr_q == $past(addr);
    endproperty
    a_latch: assert property (p_latch) else $error("array write not latched");

    property p_open;
        @(posedge clock) disable iff (rst)
        (prot_q[3:0] == 4'h0 && tgt_addr_q != fpp_pkg::PROT_ADDR) |-> !hit;
    endproperty
    a_open: assert property (p_open) else $error("cleared protection still blocks");

    property p_cov_margin;
        @(posedge clock) disable iff (rst)
        bus_q == fpp_pkg::BUS_STRETCH ##1 pready_q;
    endproperty
    c_margin: cover property (p_cov_margin);

    property p_cov_hv;
        @(posedge clock) disable iff (rst)
        $rose(high_voltage_enable_q) ##[1:1000] hv_fall;
    endproperty
    c_hv: cover property (p_cov_hv);

    property p_cov_hit;
        @(posedge clock) disable iff (rst)
        hit_live;
    endproperty
    c_hit: cover property (p_cov_hit);

endmodule

// *** dv/flash_program_protect_tb.sv ***
// Self-checking bench for the array program sequencer
`timescale 1ns/1ps

module flash_program_protect_tb;
    typedef struct packed {logic rd; logic cd; logic [31:0] data; logic err;} fpp_note_s;

    localparam logic [6:0] C_DIV = 7'h01 << fpp_pkg::CTRL_DIV;
    localparam logic [6:0] C_HV  = 7'h01 << fpp_pkg::CTRL_HIGH_VOLTAGE_ENABLE;
    localparam logic [6:0] C_MRG = 7'h01 << fpp_pkg::CTRL_MARGIN;
    localparam logic [6:0] C_ERS = 7'h01 << fpp_pkg::CTRL_ERASE;
    localparam logic [6:0] C_PGM = 7'h01 << fpp_pkg::CTRL_PGM;

    // ****************************************
    // Signals
    // ****************************************
    logic        clock;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic        test_override_voltage;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        high_voltage_enable;
    logic        pump_tick;
    fpp_note_s   notes[$];
    fpp_note_s   note;
    int          error_cnt;
    int          n_tests;
    int          lat;
    int          base_lat;
    logic [7:0]  prot;
    logic        prot_known;
    logic [15:0] a;
    logic [7:0]  d;

    fpp_sequencer fpp_sequencer_i (
        .clock                 (clock),
        .rst                   (rst),
        .psel                  (psel),
        .penable               (penable),
        .pwrite                (pwrite),
        .paddr                 (paddr),
        .pwdata                (pwdata),
        .test_override_voltage (test_override_voltage),
        .prdata                (prdata),
        .pready                (pready),
        .pslverr               (pslverr),
        .high_voltage_enable   (high_voltage_enable),
        .pump_tick             (pump_tick)
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test;
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("Error at %0t ns: %s", $time, msg);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] loc, input logic [31:0] dat,
                       input logic cd, input logic err);
        int n;
        n = 0;
        notes.push_back('{rd: !w, cd: cd, data: dat, err: err});
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {loc, 2'b00};
        pwdata <= dat;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            error_cnt++;
            end_of_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        lat = n;
    endtask

    task automatic wr(input logic [15:0] loc, input logic [31:0] dat);
        apb(1'b1, loc, dat, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [15:0] loc, input logic [31:0] e);
        apb(1'b0, loc, e, 1'b1, 1'b0);
    endtask

    // One program or erase pass, ok says whether high voltage may come on
    task automatic op(input logic [6:0] c, input logic [15:0] ta, input logic [7:0] td,
                      input logic ok, input logic [7:0] e);
        int k;
        wr(fpp_pkg::CTRL_ADDR, {25'h0, c});
        apb(1'b0, fpp_pkg::PROT_ADDR, {24'h0, prot}, prot_known, 1'b0);
        apb(1'b0, fpp_pkg::STAT_ADDR, {22'h0, prot, 2'b01}, prot_known, 1'b0);
        wr(ta, {24'h0, td});
        if (!ok)
        begin
            rd(fpp_pkg::CTRL_ADDR, 32'h0);
            rd(fpp_pkg::STAT_ADDR, {22'h0, prot, 2'b00});
        end
        wr(fpp_pkg::CTRL_ADDR, {25'h0, c | C_HV});
        chk(high_voltage_enable === ok, "high voltage state");
        if (ok)
        begin
            k = 0;
            repeat (8)
            begin
                @(negedge clock);
                k += (pump_tick === 1'b1);
            end
            @(posedge clock);
            chk(k == (c[0] ? 4 : 8), "pump tick count");
            wr(fpp_pkg::CTRL_ADDR, {25'h0, c | C_HV | C_MRG});
            rd(fpp_pkg::CTRL_ADDR, {25'h0, c | C_HV});
            wr(fpp_pkg::CTRL_ADDR, {25'h0, c});
            wr(fpp_pkg::CTRL_ADDR, {25'h0, c | C_MRG});
            wr(fpp_pkg::CTRL_ADDR, {25'h0, C_MRG});
            rd(ta, {24'h0, e});
            chk(lat == base_lat + 8, "margin read stretch");
        end
        wr(fpp_pkg::CTRL_ADDR, 32'h0);
    endtask

    // ****************************************
    // Response monitor
    // ****************************************
    always @(negedge clock)
    begin
        if (pready === 1'b1)
        begin
            n_tests++;
            if (notes.size() == 0)
            begin
                error_cnt++;
                $display("Error at %0t ns: unexpected response", $time);
            end
            else
            begin
                note = notes.pop_front();
                if (pslverr !== note.err || (note.rd && note.cd && prdata !== note.data))
                begin
                    error_cnt++;
                    $display("Error at %0t ns: got %h, expected %h", $time, prdata, note.data);
                end
            end
        end
    end

    // ****************************************
    // Stimulus
    // ****************************************
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h00000;
        pwdata = 32'h0;
        test_override_voltage = 1'b0;
        error_cnt = 0;
        n_tests = 0;
        prot = 8'h00;
        prot_known = 1'b0;
        void'($urandom(29));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(fpp_pkg::CTRL_ADDR, 32'h0);
        base_lat = lat;
        chk(base_lat == 2, "single wait state");
        rd(fpp_pkg::STAT_ADDR, 32'h0);
        apb(1'b0, 16'h0100, 32'h0, 1'b1, 1'b1);
        apb(1'b1, 16'h0100, 32'hFFFFFFFF, 1'b0, 1'b1);
        test_override_voltage <= 1'b1;
        op(C_ERS | C_DIV, 16'hFFF0, 8'hA5, 1'b1, 8'h00);
        prot_known = 1'b1;
        test_override_voltage <= 1'b0;
        op(C_ERS, fpp_pkg::ARRAY_BASE, 8'h5A, 1'b1, 8'h00);
        repeat (4) rd(16'h7800 + 16'($urandom % 2032), 32'h0);
        a = 16'h7808 + 16'($urandom % 118);
        d = 8'($urandom);
        op(C_PGM, a, d, 1'b1, d);
        wr(a, 32'hFF);
        rd(a, {24'h0, d});
        wr(fpp_pkg::CTRL_ADDR, {25'h0, C_PGM | C_ERS});
        rd(fpp_pkg::CTRL_ADDR, 32'h0);
        for (int b = 0; b < 4; b++)
        begin
            test_override_voltage <= 1'b1;
            op(C_ERS, 16'hFFF0, 8'h00, 1'b1, 8'h00);
            prot = 8'h00;
            op(C_PGM, 16'hFFF0, 8'h01 << b, 1'b1, 8'h01 << b);
            prot = 8'h01 << b;
            op(C_PGM, fpp_pkg::PROT_START[b], 8'h3C, 1'b1, 8'h3C);
            test_override_voltage <= 1'b0;
            op(C_PGM, fpp_pkg::PROT_START[b] + 16'h4, 8'hC3, 1'b0, 8'h00);
            op(C_ERS, 16'hFFF8, 8'h00, 1'b0, 8'h00);
            if (b > 0)
                op(C_PGM, fpp_pkg::PROT_START[b] - 16'h1, 8'h81, 1'b1, 8'h81);
        end
        test_override_voltage <= 1'b1;
        op(C_ERS, 16'hFFF0, 8'h00, 1'b1, 8'h00);
        prot = 8'h00;
        op(C_PGM, 16'hFFF0, 8'h06, 1'b1, 8'h06);
        prot = 8'h06;
        test_override_voltage <= 1'b0;
        op(C_PGM, 16'h78C0, 8'h11, 1'b0, 8'h00);
        end_of_test();
    end
endmodule
